// ==== design/sdc_top.sv ====
// Stepper drive control: register slave, path control, current shaping, position error
`timescale 1ns/1ps
`include "sdc_defines.svh"
module sdc_top #(
   parameter int CTRL_TICKS = `SDC_CTRL_TICKS,
   parameter int TABLE_DEPTH = 16
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [6:0] i_wb_adr,
   input wire logic [31:0] i_wb_dat,
   input wire logic [3:0] i_wb_sel,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic i_sensor_in,
   input wire logic [2:0] i_load_angle,
   output sdc_pkg::sdc_coil_type o_coil,
   output logic o_aux_drive,
   output logic o_bridge_en,
   output logic o_irq
);
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [7:0] sine_rom(input logic [3:0] i);
      case (i)
         4'h0: sine_rom = 8'h0D;
         4'h1: sine_rom = 8'h25;
         4'h2: sine_rom = 8'h3E;
         4'h3: sine_rom = 8'h56;
         4'h4: sine_rom = 8'h6D;
         4'h5: sine_rom = 8'h83;
         4'h6: sine_rom = 8'h98;
         4'h7: sine_rom = 8'hAB;
         4'h8: sine_rom = 8'hBD;
         4'h9: sine_rom = 8'hCD;
         4'hA: sine_rom = 8'hDB;
         4'hB: sine_rom = 8'hE7;
         4'hC: sine_rom = 8'hF0;
         4'hD: sine_rom = 8'hF7;
         4'hE: sine_rom = 8'hFC;
         default: sine_rom = 8'hFF;
      endcase
   endfunction

   // Index into the quarter table for a phase; odd quadrants run backwards
   function automatic logic [3:0] quarter_idx(input logic [5:0] ph);
      return ph[4] ? ~ph[3:0] : ph[3:0];
   endfunction

   logic [23:0] ctrl;
   logic [15:0] tgt_lo, tgt_hi, feature, full_steps, ppr, vel_period, acc_period;
   logic [2:0] qps;
   logic [7:0] hold_auto, hold_man;
   logic [2:0] irq_stat, irq_mask;
   logic [7:0] cur_table [TABLE_DEPTH];
   logic [31:0] rd_data, wr_word;
   logic signed [31:0] pos, target, pos_err;
   logic [31:0] pulse_cnt;
   logic [20:0] pulse_factor;
   logic tgt_ack, ld_prev, clr_prev;
   logic [2:0] load_angle;
   logic sens_s1, sens_s2, sens_s3;
   logic [2:0] la_s1, la_s2;
   sdc_pkg::sdc_motion_type motion;
   logic [15:0] step_cnt, cur_period;
   logic [5:0] phase;
   logic [10:0] tick_cnt;
   logic ctrl_tick;

   wire req = i_wb_cyc & i_wb_stb;
   wire commit = req & o_wb_ack;
   wire wr = commit & i_wb_we;
   wire [4:0] widx = i_wb_adr[6:2];
   wire tbl_sel = widx[`SDC_REG_TABLE_BIT];
   assign wr_word = merge(rd_data, i_wb_dat, i_wb_sel);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end else if (i_ce) begin
         o_wb_ack <= req & ~o_wb_ack;
         if (req & ~o_wb_ack) begin
            o_wb_dat <= rd_data;
         end
      end
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      if (tbl_sel) begin
         rd_data = {24'h00_0000, cur_table[widx[3:0]]};
      end else begin
         case (widx)
            `SDC_REG_CTRL: rd_data = {8'h00, ctrl};
            `SDC_REG_STAT_BYTE: rd_data = {28'h000_0000, load_angle, 1'b0};
            `SDC_REG_STAT_WORD: rd_data = {29'h0000_0000, tgt_ack, 2'h0};
            `SDC_REG_TGT_LO: rd_data = {16'h0000, tgt_lo};
            `SDC_REG_TGT_HI: rd_data = {16'h0000, tgt_hi};
            `SDC_REG_FEATURE: rd_data = {16'h0000, feature};
            `SDC_REG_FULL_STEPS: rd_data = {16'h0000, full_steps};
            `SDC_REG_PPR: rd_data = {16'h0000, ppr};
            `SDC_REG_QPS: rd_data = {29'h0000_0000, qps};
            `SDC_REG_HOLD: rd_data = {16'h0000, hold_man, hold_auto};
            `SDC_REG_VEL: rd_data = {16'h0000, vel_period};
            `SDC_REG_ACC: rd_data = {16'h0000, acc_period};
            // Error replaces position while display bit is set
            `SDC_REG_DATA_IN: rd_data = ctrl[`SDC_CW_POS_ERR] ? pos_err : pos; // [R14]
            `SDC_REG_POS: rd_data = target;
            `SDC_REG_IRQ_STAT: rd_data = {29'h0000_0000, irq_stat};
            `SDC_REG_IRQ_MASK: rd_data = {29'h0000_0000, irq_mask};
            default: rd_data = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl <= 24'h00_0000;
         tgt_lo <= 16'h0000;
         tgt_hi <= 16'h0000;
         feature <= 16'h0000;
         full_steps <= `SDC_RST_FULL_STEPS;
         ppr <= `SDC_RST_PPR;
         qps <= `SDC_RST_QPS;
         hold_auto <= `SDC_RST_HOLD_AUTO;
         hold_man <= `SDC_RST_HOLD_MAN;
         vel_period <= `SDC_RST_VEL;
         acc_period <= `SDC_RST_ACC;
         irq_mask <= 3'h0;
      end else if (i_ce && wr && !tbl_sel) begin
         case (widx)
            `SDC_REG_CTRL: ctrl <= wr_word[23:0];
            `SDC_REG_TGT_LO: tgt_lo <= wr_word[15:0];
            `SDC_REG_TGT_HI: tgt_hi <= wr_word[15:0];
            `SDC_REG_FEATURE: feature <= wr_word[15:0];
            `SDC_REG_FULL_STEPS: full_steps <= wr_word[15:0];
            `SDC_REG_PPR: ppr <= wr_word[15:0];
            // Beyond 16 microsteps per full step the 64-step period has no finer resolution
            `SDC_REG_QPS: qps <= (wr_word[2:0] > `SDC_QPS_MAX) ? `SDC_QPS_MAX : wr_word[2:0]; // [R1]
            `SDC_REG_HOLD: {hold_man, hold_auto} <= wr_word[15:0];
            `SDC_REG_VEL: vel_period <= wr_word[15:0];
            `SDC_REG_ACC: acc_period <= wr_word[15:0];
            `SDC_REG_IRQ_MASK: irq_mask <= wr_word[2:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < TABLE_DEPTH; i++) begin
            cur_table[i] <= sine_rom(4'(i));
         end
      end else if (i_ce && wr && tbl_sel) begin
         cur_table[widx[3:0]] <= wr_word[7:0];
      end
   end

   // Sensor and load angle come from pins
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         {sens_s1, sens_s2, sens_s3} <= 3'h0;
         la_s1 <= 3'h0;
         la_s2 <= 3'h0;
      end else if (i_ce) begin
         {sens_s1, sens_s2, sens_s3} <= {i_sensor_in, sens_s1, sens_s2};
         la_s1 <= i_load_angle;
         la_s2 <= la_s1;
      end
   end
   wire sens_rise = sens_s2 & ~sens_s3;

   // Target load and clear
   wire ld_rise = ctrl[`SDC_CW_TGT_LOAD] & ~ld_prev;
   wire clr_rise = ctrl[`SDC_CW_TGT_CLR] & ~clr_prev;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ld_prev <= 1'b0;
         clr_prev <= 1'b0;
         target <= 32'sh0000_0000;
         tgt_ack <= 1'b0;
      end else if (i_ce) begin
         ld_prev <= ctrl[`SDC_CW_TGT_LOAD];
         clr_prev <= ctrl[`SDC_CW_TGT_CLR];
         if (clr_rise) begin
            target <= pos; // [R9]
         end else if (ld_rise) begin
            target <= {tgt_hi, tgt_lo}; // [R10]
         end
         // Acknowledge holds until both command bits return low
         if (clr_rise || ld_rise) begin
            tgt_ack <= 1'b1; // [R11]
         end else if (!ctrl[`SDC_CW_TGT_LOAD] && !ctrl[`SDC_CW_TGT_CLR]) begin
            tgt_ack <= 1'b0;
         end
      end
   end

   // Path control with a linear period ramp from the acceleration start period
   wire enabled = ctrl[`SDC_CB_ENABLE];
   wire dir_up = target > pos;
   wire [5:0] step_inc = `SDC_QUARTER_STEPS >> qps; // [R17]
   wire step_now = (motion == sdc_pkg::SDC_RUN) && (step_cnt == 16'h0000);
   wire [5:0] next_phase = dir_up ? phase + step_inc : phase - step_inc;
   wire full_step = step_now && (next_phase[3:0] == 4'h0);
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         motion <= sdc_pkg::SDC_IDLE;
         pos <= 32'sh0000_0000;
         phase <= 6'h00;
         step_cnt <= 16'h0000;
         cur_period <= 16'h0000;
      end else if (i_ce) begin
         case (motion)
            sdc_pkg::SDC_IDLE: begin
               if (enabled && pos != target) begin
                  motion <= sdc_pkg::SDC_RUN; // [R12]
                  cur_period <= acc_period;
                  step_cnt <= acc_period;
               end
            end
            sdc_pkg::SDC_RUN: begin
               if (!enabled || pos == target) begin
                  motion <= sdc_pkg::SDC_IDLE;
               end else if (step_now) begin
                  pos <= dir_up ? pos + 32'sd1 : pos - 32'sd1;
                  phase <= next_phase; // [R1]
                  cur_period <= (cur_period > vel_period) ? cur_period - 16'h0001 : vel_period;
                  step_cnt <= (cur_period > vel_period) ? cur_period - 16'h0001 : vel_period;
               end else begin
                  step_cnt <= step_cnt - 16'h0001;
               end
            end
            default: motion <= sdc_pkg::SDC_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         load_angle <= 3'h0;
      end else if (i_ce && full_step) begin
         load_angle <= la_s2; // [R2]
      end
   end

   // Current loop rate
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tick_cnt <= 11'h000;
         ctrl_tick <= 1'b0;
      end else if (i_ce) begin
         ctrl_tick <= (tick_cnt == 11'(CTRL_TICKS - 1));
         tick_cnt <= (tick_cnt == 11'(CTRL_TICKS - 1)) ? 11'h000 : tick_cnt + 11'h001; // [R19]
      end
   end

   // Current percentage: manual beats automatic, which applies only at standstill
   logic [7:0] pct;
   always_comb begin
      if (ctrl[`SDC_CB_HOLD] || ctrl[`SDC_CW_HOLD]) begin
         pct = hold_man; // [R8]
      end else if (motion != sdc_pkg::SDC_RUN) begin
         pct = hold_auto; // [R7]
      end else begin
         pct = `SDC_PCT_FULL;
      end
   end

   wire custom = feature[`SDC_FEAT_CUSTOM];
   wire [5:0] phase_b = phase + `SDC_QUARTER_STEPS;
   wire [7:0] mag_a = custom ? cur_table[quarter_idx(phase)] : sine_rom(quarter_idx(phase)); // [R3]
   wire [7:0] mag_b = custom ? cur_table[quarter_idx(phase_b)] : sine_rom(quarter_idx(phase_b)); // [R3]
   // Scaled by the current percentage pct out of 100, full scale 255
   wire [15:0] amp_a = 16'(mag_a * pct) / 16'h0064;
   wire [15:0] amp_b = 16'(mag_b * pct) / 16'h0064;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_coil <= '0;
         o_bridge_en <= 1'b0;
      end else if (i_ce) begin
         o_bridge_en <= enabled;
         if (ctrl_tick) begin
            o_coil.a <= phase[5] ? -$signed({1'b0, amp_a[7:0]}) : $signed({1'b0, amp_a[7:0]}); // [R19]
            o_coil.b <= phase_b[5] ? -$signed({1'b0, amp_b[7:0]}) : $signed({1'b0, amp_b[7:0]}); // [R19]
         end
      end
   end

   // Mixed decay; position may shift a few microsteps when it is turned off
   wire second_half = (motion == sdc_pkg::SDC_RUN) && (step_cnt < (cur_period >> 1));
   wire md_active = enabled && !ctrl[`SDC_CW_MD_DIS]; // [R5]
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_aux_drive <= 1'b0;
      end else if (i_ce) begin
         o_aux_drive <= md_active && second_half && tick_cnt[3]; // [R4]
      end
   end

   // Pulse factor by serial division
   logic [20:0] div_num, div_quo;
   logic [15:0] div_rem;
   logic [4:0] div_cnt;
   wire [20:0] ms_steps = 21'({5'h00, full_steps} << qps); // [R15]
   wire [16:0] rem_sh = {div_rem, div_num[20]};
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_num <= 21'h00_0000;
         div_quo <= 21'h00_0000;
         div_rem <= 16'h0000;
         div_cnt <= 5'h00;
         pulse_factor <= 21'h00_0000;
      end else if (i_ce) begin
         if (div_cnt == 5'h00) begin
            pulse_factor <= (ppr == 16'h0000) ? 21'h00_0000 : div_quo; // [R15]
            div_num <= ms_steps;
            div_rem <= 16'h0000;
            div_quo <= 21'h00_0000;
            div_cnt <= 5'h15;
         end else begin
            div_num <= {div_num[19:0], 1'b0};
            if (rem_sh >= {1'b0, ppr}) begin
               div_rem <= 16'(rem_sh - {1'b0, ppr});
               div_quo <= {div_quo[19:0], 1'b1};
            end else begin
               div_rem <= rem_sh[15:0];
               div_quo <= {div_quo[19:0], 1'b0};
            end
            div_cnt <= div_cnt - 5'h01;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pulse_cnt <= 32'h0000_0000;
         pos_err <= 32'sh0000_0000;
      end else if (i_ce) begin
         if (sens_rise) begin
            pulse_cnt <= pulse_cnt + 32'h0000_0001; // [R13]
         end
         // Raw difference: start offset and switching delay stay in the result
         pos_err <= pos - $signed(32'(pulse_cnt * pulse_factor)); // [R16] [R18]
      end
   end

   // Events are sticky, a read of the status clears; a new event wins
   wire [2:0] irq_evt = {sens_rise, full_step, clr_rise | ld_rise};
   wire irq_rd = commit && !i_wb_we && !tbl_sel && widx == `SDC_REG_IRQ_STAT;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_stat <= 3'h0;
         o_irq <= 1'b0;
      end else if (i_ce) begin
         irq_stat <= (irq_rd ? 3'h0 : irq_stat) | irq_evt;
         o_irq <= |(irq_stat & irq_mask);
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_load_edge;
      i_ce && ld_rise && !clr_rise;
   endsequence

   wb_ack_pulse_a: assert property (o_wb_ack && i_ce |=> !o_wb_ack) else $error("ack longer than one cycle");
   wb_ack_follow_a: assert property (req && !o_wb_ack && i_ce |=> o_wb_ack) else $error("ack missing");
   clear_wins_a: assert property (i_ce && clr_rise |=> target == $past(pos)) else $error("clear lost"); // [R9]
   load_copies_a: assert property (s_load_edge |=> target == {$past(tgt_hi), $past(tgt_lo)}) // [R10]
      else $error("target not loaded");
   tgt_ack_set_a: assert property (i_ce && (ld_rise || clr_rise) |=> tgt_ack) else $error("no ack"); // [R11]
   hold_manual_a: assert property (ctrl[`SDC_CW_HOLD] |-> pct == hold_man) else $error("manual hold"); // [R8]
   hold_auto_a: assert property (!ctrl[`SDC_CW_HOLD] && !ctrl[`SDC_CB_HOLD] && motion == sdc_pkg::SDC_IDLE // [R7]
      |-> pct == hold_auto) else $error("auto hold");
   md_off_a: assert property (ctrl[`SDC_CW_MD_DIS] && i_ce |=> !o_aux_drive) else $error("aux while off"); // [R5]
   la_stable_a: assert property (i_ce && !full_step |=> $stable(load_angle)) else $error("angle moved"); // [R2]
   coil_rate_a: assert property (!ctrl_tick |=> $stable(o_coil)) else $error("coil off tick"); // [R19]
endmodule

// ==== design/sdc_defines.svh ====
// Register map, field positions, reset values and timing counts of the stepper drive control
// Operation
// [R1] Up to 64 microsteps per electrical period
// [R2] Three-bit load angle refreshed every full step
// [R3] Custom current table replaces sine when enabled
// [R4] Mixed decay pulses aux transistor in second half
// [R5] Mixed decay off while disable bit set
// [R6] Controller keeps mixed decay off when slow; the code has no speed check and pulses aux at every speed
// [R7] Standstill applies auto hold percent of coil current
// [R8] Manual hold bits apply manual hold percent
// [R9] Clear edge deletes target, beats load
// [R10] Load edge copies target words into target
// [R11] Target acknowledge bit confirms load or clear
// [R12] Path control travels to 32-bit target autonomously
// [R13] Count sensor pulses on digital input two
// [R14] Display bit shows position error in data
// [R15] Pulse factor is microsteps times steps per pulses
// [R16] Error is position minus pulses times factor
// [R17] Microsteps per full step is two to size
// [R18] No start offset or sensor delay compensation
// [R19] Coil current loop updates at 25 kHz
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH
`define SDC_REG_CTRL 5'h00
`define SDC_REG_STAT_BYTE 5'h01
`define SDC_REG_STAT_WORD 5'h02
`define SDC_REG_TGT_LO 5'h03
`define SDC_REG_TGT_HI 5'h04
`define SDC_REG_FEATURE 5'h05
`define SDC_REG_FULL_STEPS 5'h06
`define SDC_REG_PPR 5'h07
`define SDC_REG_QPS 5'h08
`define SDC_REG_HOLD 5'h09
`define SDC_REG_VEL 5'h0A
`define SDC_REG_ACC 5'h0B
`define SDC_REG_DATA_IN 5'h0C
`define SDC_REG_POS 5'h0D
`define SDC_REG_IRQ_STAT 5'h0E
`define SDC_REG_IRQ_MASK 5'h0F
`define SDC_REG_TABLE_BIT 4
`define SDC_CW_POS_ERR 7
`define SDC_CW_MD_DIS 9
`define SDC_CW_TGT_LOAD 10
`define SDC_CW_HOLD 11
`define SDC_CW_TGT_CLR 13
`define SDC_CB_ENABLE 16
`define SDC_CB_HOLD 19
`define SDC_SW_TGT_ACK 2
`define SDC_SB_LA_LSB 1
`define SDC_FEAT_CUSTOM 7
`define SDC_IRQ_ACK 0
`define SDC_IRQ_STEP 1
`define SDC_IRQ_PULSE 2
`define SDC_RST_FULL_STEPS 16'h00C8
`define SDC_RST_PPR 16'h0001
`define SDC_RST_QPS 3'h4
`define SDC_RST_HOLD_AUTO 8'h32
`define SDC_RST_HOLD_MAN 8'h32
`define SDC_RST_VEL 16'h0100
`define SDC_RST_ACC 16'h0400
`define SDC_PCT_FULL 8'h64
`define SDC_QPS_MAX 3'h4
`define SDC_QUARTER_STEPS 6'h10
`define SDC_CLK_HZ 40000000
`define SDC_CTRL_RATE_HZ 25000
`define SDC_CTRL_TICKS (`SDC_CLK_HZ / `SDC_CTRL_RATE_HZ)
`endif

// ==== design/sdc_pkg.sv ====
// Types shared by the stepper drive control
package sdc_pkg;
   typedef enum logic [1:0] {
      SDC_IDLE = 2'b00,
      SDC_RUN = 2'b01
   } sdc_motion_type;
   typedef struct packed {
      logic signed [8:0] a;
      logic signed [8:0] b;
   } sdc_coil_type;
endpackage

// ==== bench/sdc_sensor_model.sv ====
// Model of the pulse sensor and load angle source facing the drive
`timescale 1ns/1ps
module sdc_sensor_model (
   input wire logic i_clk,
   input wire logic [3:0] i_pulses,
   input wire logic [2:0] i_angle,
   output logic o_sensor,
   output logic [2:0] o_load_angle
);
   // Counters start at zero without a second process driving them
   int sent = 0;
   int ph = 0;
   // Pulses of four cycles high, four low, then rest low
   always @(posedge i_clk) begin
      if (sent < i_pulses) begin
         ph <= (ph == 7) ? 0 : ph + 1;
         if (ph == 7) begin
            sent <= sent + 1;
         end
         o_sensor <= (ph < 4);
      end else begin
         o_sensor <= 1'b0;
      end
   end
   assign o_load_angle = i_angle;
endmodule

// ==== bench/tb.sv ====
// Self-checking bench of the stepper drive control over its register bus
`timescale 1ns/1ps
module tb;
   logic i_clk, i_rst_n, cyc, we, sensor, aux, bridge, irq, ack;
   // Cycles with aux high are counted by one process; scenarios compare against a snapshot
   int aux_hits = 0;
   int aux_base;
   logic [6:0] adr;
   logic [31:0] wdat, rd, odat;
   logic [3:0] pulses;
   logic [2:0] angle, la;
   sdc_pkg::sdc_coil_type coil;
   int bad_count, n_compared;
   logic [6:0] ra [6] = '{7'h18, 7'h1C, 7'h20, 7'h24, 7'h28, 7'h2C};
   logic [31:0] rv [6] = '{32'h000000C8, 32'h00000001, 32'h00000004, 32'h00003232, 32'h00000100, 32'h00000400};
   logic [31:0] hb [2] = '{32'h00010800, 32'h00090000};
   // Short current-loop tick keeps the run brief
   sdc_top #(.CTRL_TICKS(16), .TABLE_DEPTH(16)) i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1),
      .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hF),
      .o_wb_dat(odat), .o_wb_ack(ack), .i_sensor_in(sensor), .i_load_angle(la), .o_coil(coil),
      .o_aux_drive(aux), .o_bridge_en(bridge), .o_irq(irq));
   sdc_sensor_model i_sensor (.i_clk(i_clk), .i_pulses(pulses), .i_angle(angle), .o_sensor(sensor),
      .o_load_angle(la));
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      if (aux === 1'b1) begin
         aux_hits <= aux_hits + 1;
      end
   end
   task automatic tally_and_finish();
      if (bad_count == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Ack is read at the edge, before that edge's updates land
   task automatic acc(input logic w, input logic [6:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge i_clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rd = odat;
      cyc <= 1'b0;
      if (n >= 50) begin
         bad_count++;
         tally_and_finish();
      end
   endtask
   task automatic rdchk(input logic [6:0] a, input logic [31:0] m, input logic [31:0] exp);
      acc(1'b0, a, 32'h00000000);
      chk(rd & m, exp);
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic wait_pos(input logic [31:0] p);
      int k;
      k = 0;
      do begin
         acc(1'b0, 7'h30, 32'h00000000);
         k++;
      end while (rd !== p && k < 400);
      chk(rd, p);
      if (k >= 400) begin
         tally_and_finish();
      end
   endtask
   initial begin
      i_rst_n = 1'b0;
      cyc = 1'b0;
      we = 1'b0;
      adr = 7'h00;
      wdat = 32'h00000000;
      pulses = 4'h0;
      angle = 3'h0;
      aux_base = 0;
      bad_count = 0;
      n_compared = 0;
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         rdchk(ra[i], 32'hFFFFFFFF, rv[i]);
      end
      acc(1'b1, 7'h20, 32'h00000007);
      rdchk(7'h20, 32'hFFFFFFFF, 32'h00000004);
      // Target load, acknowledge and interrupt
      acc(1'b1, 7'h0C, 32'h00002345);
      acc(1'b1, 7'h10, 32'h00000001);
      acc(1'b1, 7'h3C, 32'h00000001);
      acc(1'b1, 7'h00, 32'h00000400);
      rdchk(7'h34, 32'hFFFFFFFF, 32'h00012345);
      rdchk(7'h08, 32'h00000004, 32'h00000004);
      chk({31'h0, irq}, 32'h00000001);
      rdchk(7'h38, 32'h00000001, 32'h00000001);
      waitc(2);
      chk({31'h0, irq}, 32'h00000000);
      acc(1'b1, 7'h00, 32'h00000000);
      rdchk(7'h08, 32'h00000004, 32'h00000000);
      acc(1'b1, 7'h00, 32'h00002400);
      rdchk(7'h34, 32'hFFFFFFFF, 32'h00000000);
      // Hold current: auto 0 %, manual 100 %
      acc(1'b1, 7'h24, 32'h00006400);
      for (int i = 0; i < 2; i++) begin
         acc(1'b1, 7'h00, hb[i]);
         waitc(40);
         chk({31'h0, coil.b != 9'h000}, 32'h00000001);
      end
      acc(1'b1, 7'h00, 32'h00010000);
      waitc(40);
      chk({14'h0, coil}, 32'h00000000);
      // Move 8 microsteps at 4 per full step, mixed decay off
      acc(1'b1, 7'h00, 32'h00000000);
      acc(1'b1, 7'h20, 32'h00000002);
      acc(1'b1, 7'h18, 32'h00000002);
      acc(1'b1, 7'h28, 32'h00000008);
      acc(1'b1, 7'h2C, 32'h0000000A);
      acc(1'b1, 7'h0C, 32'h00000008);
      acc(1'b1, 7'h10, 32'h00000000);
      angle <= 3'h5;
      pulses <= 4'h2;
      aux_base = aux_hits;
      acc(1'b1, 7'h00, 32'h00010600);
      wait_pos(32'h00000008);
      chk(32'(aux_hits - aux_base), 32'h00000000);
      chk({31'h0, bridge}, 32'h00000001);
      rdchk(7'h04, 32'h0000000E, 32'h0000000A);
      // Error is 8 minus 2 pulses times factor 4*2/1
      acc(1'b1, 7'h00, 32'h00010080);
      waitc(30);
      rdchk(7'h30, 32'hFFFFFFFF, 32'hFFFFFFF8);
      // Longer move with mixed decay on
      acc(1'b1, 7'h0C, 32'h00000040);
      aux_base = aux_hits;
      acc(1'b1, 7'h00, 32'h00010400);
      wait_pos(32'h00000040);
      chk({31'h0, aux_hits != aux_base}, 32'h00000001);
      // All-zero custom table removes the held current
      for (int i = 0; i < 16; i++) begin
         acc(1'b1, 7'h40 + 7'(i * 4), 32'h00000000);
      end
      acc(1'b1, 7'h14, 32'h00000080);
      acc(1'b1, 7'h00, 32'h00010800);
      waitc(40);
      chk({14'h0, coil}, 32'h00000000);
      tally_and_finish();
   end
endmodule
